// ==== pkg/dlcsr_pkg.sv ====
// Shared constants and types for the debug link control/status register block
package dlcsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets inside the control/status space
  localparam logic [1:0] OFS_LINK_STATUS       = 2'h0;
  localparam logic [1:0] OFS_REMOTE_RESET_HOLD = 2'h1;
  localparam logic [1:0] OFS_LINK_CONTROL      = 2'h2;
  localparam logic [1:0] OFS_RESERVED_SLOT     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and widths
  localparam int unsigned POS_MEM_PROG_ENABLED = 1;
  localparam int unsigned POS_RESET_STATE      = 0;
  localparam int unsigned IDLE_SEL_W           = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0]            RST_LINK_STATUS       = 8'h00;
  localparam logic [7:0]            RST_REMOTE_RESET_HOLD = 8'h00;
  localparam logic [IDLE_SEL_W-1:0] RST_IDLE_SELECT       = 3'h0;

  // Byte that holds the whole device in reset while stored
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;

  ////////////////////////////////////////////////////////////////////////////
  // Turnaround idle bit counts, one link clock per idle bit
  localparam logic [7:0] IDLE_BITS_128 = 8'h80;
  localparam logic [7:0] IDLE_BITS_64  = 8'h40;
  localparam logic [7:0] IDLE_BITS_32  = 8'h20;
  localparam logic [7:0] IDLE_BITS_16  = 8'h10;
  localparam logic [7:0] IDLE_BITS_8   = 8'h08;
  localparam logic [7:0] IDLE_BITS_4   = 8'h04;
  localparam logic [7:0] IDLE_BITS_2   = 8'h02;

  // Stages of every synchroniser
  localparam int unsigned SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // One single-byte load or store from the instruction decoder
  typedef struct packed {
    logic       write;  // 1 = store, 0 = load
    logic [1:0] addr;   // Direct address from the instruction
    logic [7:0] wdata;  // Store data
  } dlcsr_req_type;

  // Answer to a load or store
  typedef struct packed {
    logic       ack;    // One-cycle completion pulse
    logic [7:0] rdata;  // Load data, zero after a store
  } dlcsr_rsp_type;

  // Direction of the half-duplex link
  typedef enum logic [1:0] {
    DIR_RX,
    DIR_GUARD,
    DIR_TX
  } dlcsr_dir_type;

endpackage : dlcsr_pkg

// ==== design/dlcsr_sync.sv ====
// Two-flop level synchroniser with synchronous reset
`timescale 1ns/1ns
`default_nettype none

module dlcsr_sync
  #(parameter int unsigned WIDTH = 1)
  (
    input  wire logic             clk_i,   // Destination clock
    input  wire logic             rst_i,   // Synchronous reset, high
    input  wire logic [WIDTH-1:0] d_i,     // Level from the other domain
    output var  logic [WIDTH-1:0] q_o      // Synchronised level
  );
  import dlcsr_pkg::*;

  logic [WIDTH-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second one, never any logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : dlcsr_sync

`default_nettype wire

// ==== design/dlcsr_top.sv ====
// Control/status register space and turnaround guard of the debug link
`timescale 1ns/1ns
`default_nettype none

module dlcsr_top
  (
    input  wire logic                    core_clk_i,     // Core clock, 50 MHz
    input  wire logic                    rst_i,          // Sync reset, high
    input  wire logic                    link_clk_i,     // Link bit clock
    input  wire logic                    cs_valid_i,     // Load/store strobe
    input  wire dlcsr_pkg::dlcsr_req_type cs_req_i,      // Load/store request
    input  wire logic                    key_ok_i,       // Key accepted pulse
    input  wire logic                    tx_turn_req_i,  // Wants to transmit
    output var  dlcsr_pkg::dlcsr_rsp_type cs_rsp_o,      // Load/store answer
    output var  logic                    guard_busy_o,   // Idle bits running
    output var  logic                    tx_grant_o,     // Transmit allowed
    output var  logic                    link_nvm_en_o,  // NVM gate, link side
    output var  logic                    device_reset_o, // Device held, core
    output var  logic                    nvm_if_en_o     // NVM gate, core side
  );
  import dlcsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                  link_rst;          // Reset seen in link domain
  logic                  mem_prog_enabled_r; // Status bit 1
  logic [7:0]            reset_hold_r;      // Whole reset register byte
  logic                  hold_active_r;     // Signature currently stored
  logic [IDLE_SEL_W-1:0] turnaround_idle_select_r;
  logic                  reset_state_link;  // Device reset echoed back
  logic                  nvm_en_core;       // Enable seen in core domain
  logic                  hold_core;         // Hold seen in core domain
  dlcsr_dir_type         dir_r;
  logic [7:0]            guard_cnt_r;
  logic [7:0]            guard_load;
  logic                  st_status;
  logic                  st_reset;
  logic                  st_control;
  logic [7:0]            rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Reset into the link domain
  // The link clock may be slow or stopped, so rst_i is carried over
  // with its own synchroniser; hold rst_i long enough to be seen.
  dlcsr_sync #(.WIDTH(1)) u_link_rst_sync
  (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (rst_i),
    .q_o   (link_rst)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Store decode
  // The address is taken straight from the request; no pointer input
  // exists, so indirect addressing cannot reach this space.
  // Each strobe moves one byte at one direct address.
  always_comb
  begin
    st_status  = 1'b0;
    st_reset   = 1'b0;
    st_control = 1'b0;
    if (cs_valid_i && cs_req_i.write)
    begin
      if (cs_req_i.addr == OFS_LINK_STATUS)
      begin
        st_status = 1'b1;
      end
      else if (cs_req_i.addr == OFS_REMOTE_RESET_HOLD)
      begin
        st_reset = 1'b1;
      end
      else if (cs_req_i.addr == OFS_LINK_CONTROL)
      begin
        st_control = 1'b1;
      end
      else
      begin
        st_status = 1'b0;  // Reserved slot: store dropped
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory-programming-enabled flag
  // Key acceptance wins over a clearing store in the same cycle so
  // that a freshly accepted key is never lost.
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      mem_prog_enabled_r <= RST_LINK_STATUS[POS_MEM_PROG_ENABLED];
    end
    else if (key_ok_i)
    begin
      mem_prog_enabled_r <= 1'b1;
    end
    else if (st_status)
    begin
      mem_prog_enabled_r <= 1'b0;
    end
  end

  // Link-side copy of the enable for the memory interface gate
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      link_nvm_en_o <= 1'b0;
    end
    else
    begin
      link_nvm_en_o <= mem_prog_enabled_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset hold register
  // The full byte is kept so that any other value releases the hold.
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      reset_hold_r <= RST_REMOTE_RESET_HOLD;
    end
    else if (st_reset)
    begin
      reset_hold_r <= cs_req_i.wdata;
    end
  end

  // Registered compare, so the crossing sees a clean flop output
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      hold_active_r <= 1'b0;
    end
    else
    begin
      hold_active_r <= (reset_hold_r == RESET_SIGNATURE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guard time selection
  // Reserved control bits are simply not stored.
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      turnaround_idle_select_r <= RST_IDLE_SELECT;
    end
    else if (st_control)
    begin
      turnaround_idle_select_r <= cs_req_i.wdata[IDLE_SEL_W-1:0];
    end
  end

  // Idle bit count for the current selection
  always_comb
  begin
    case (turnaround_idle_select_r)
      3'h0:    guard_load = IDLE_BITS_128;
      3'h1:    guard_load = IDLE_BITS_64;
      3'h2:    guard_load = IDLE_BITS_32;
      3'h3:    guard_load = IDLE_BITS_16;
      3'h4:    guard_load = IDLE_BITS_8;
      3'h5:    guard_load = IDLE_BITS_4;
      default: guard_load = IDLE_BITS_2;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Turnaround state machine
  // Receive to transmit passes through the guard; transmit to receive
  // is immediate, since the far end is already waiting to drive.
  // This logic never sees the device reset, so the link keeps
  // answering while the device is held.
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      dir_r <= DIR_RX;
    end
    else
    begin
      case (dir_r)
        DIR_RX:
        begin
          if (tx_turn_req_i)
          begin
            dir_r <= DIR_GUARD;
          end
        end
        DIR_GUARD:
        begin
          if (!tx_turn_req_i)
          begin
            dir_r <= DIR_RX;
          end
          else if (guard_cnt_r == 8'h01)
          begin
            dir_r <= DIR_TX;
          end
        end
        DIR_TX:
        begin
          if (!tx_turn_req_i)
          begin
            dir_r <= DIR_RX;
          end
        end
        default:
        begin
          dir_r <= DIR_RX;
        end
      endcase
    end
  end

  // Idle bit counter, loaded on entry to the guard
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      guard_cnt_r <= 8'h00;
    end
    else if (dir_r == DIR_RX && tx_turn_req_i)
    begin
      guard_cnt_r <= guard_load;
    end
    else if (dir_r == DIR_GUARD && guard_cnt_r != 8'h00)
    begin
      guard_cnt_r <= guard_cnt_r - 8'h01;
    end
  end

  // Direction outputs, registered alongside the state
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      guard_busy_o <= 1'b0;
      tx_grant_o   <= 1'b0;
    end
    else
    begin
      guard_busy_o <= (dir_r == DIR_RX && tx_turn_req_i) ||
                      (dir_r == DIR_GUARD && tx_turn_req_i &&
                       guard_cnt_r != 8'h01);
      tx_grant_o   <= tx_turn_req_i &&
                      ((dir_r == DIR_TX) ||
                       (dir_r == DIR_GUARD && guard_cnt_r == 8'h01));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings toward the core domain
  // Both are slow levels, so plain two-flop synchronisers do.
  dlcsr_sync #(.WIDTH(2)) u_core_sync
  (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   ({hold_active_r, mem_prog_enabled_r}),
    .q_o   ({hold_core, nvm_en_core})
  );

  // Core-side outputs
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      device_reset_o <= 1'b0;
      nvm_if_en_o    <= 1'b0;
    end
    else
    begin
      device_reset_o <= hold_core;
      nvm_if_en_o    <= nvm_en_core;
    end
  end

  // Reset state echoed back, so a read shows what the device sees
  dlcsr_sync #(.WIDTH(1)) u_echo_sync
  (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   (device_reset_o),
    .q_o   (reset_state_link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Load data mux
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (cs_valid_i && !cs_req_i.write)
    begin
      if (cs_req_i.addr == OFS_LINK_STATUS)
      begin
        rdata_nxt[POS_MEM_PROG_ENABLED] = mem_prog_enabled_r;
      end
      else if (cs_req_i.addr == OFS_REMOTE_RESET_HOLD)
      begin
        // Upper seven bits stay zero even while held
        rdata_nxt[POS_RESET_STATE] = reset_state_link;
      end
      else if (cs_req_i.addr == OFS_LINK_CONTROL)
      begin
        rdata_nxt[IDLE_SEL_W-1:0] = turnaround_idle_select_r;
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // Answer one link clock after the strobe
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      cs_rsp_o <= '0;
    end
    else
    begin
      cs_rsp_o.ack   <= cs_valid_i;
      cs_rsp_o.rdata <= rdata_nxt;
    end
  end

endmodule : dlcsr_top

`default_nettype wire

// ==== bench/dlcsr_top_assertions.sv ====
// Port checks for the debug link control/status block
`timescale 1ns/1ns
`default_nettype none

module dlcsr_top_assertions
  import dlcsr_pkg::*;
  (
    input wire logic          core_clk_i,     // Core clock
    input wire logic          rst_i,          // Reset, high
    input wire logic          link_clk_i,     // Link clock
    input wire logic          cs_valid_i,     // Access strobe
    input wire dlcsr_req_type cs_req_i,       // Access request
    input wire logic          key_ok_i,       // Key accepted
    input wire logic          tx_turn_req_i,  // Transmit wish
    input wire dlcsr_rsp_type cs_rsp_o,       // Access answer
    input wire logic          guard_busy_o,   // Guard running
    input wire logic          tx_grant_o,     // Transmit allowed
    input wire logic          link_nvm_en_o,  // Enable, link side
    input wire logic          device_reset_o, // Device held
    input wire logic          nvm_if_en_o     // Enable, core side
  );

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current guard, so a stuck counter shows up
  logic [7:0] guard_run_r;
  always_ff @(posedge link_clk_i)
  begin
    if (rst_i || !guard_busy_o)
      guard_run_r <= 8'h00;
    else
      guard_run_r <= guard_run_r + 8'h01;
  end

  sequence s_spare_load;
    cs_valid_i && !cs_req_i.write && cs_req_i.addr == OFS_RESERVED_SLOT;
  endsequence
  sequence s_hold_load;
    cs_valid_i && !cs_req_i.write && cs_req_i.addr == OFS_REMOTE_RESET_HOLD;
  endsequence
  sequence s_status_store;
    cs_valid_i && cs_req_i.write && cs_req_i.addr == OFS_LINK_STATUS && !key_ok_i;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_ack_next_cycle: assert property (@(posedge link_clk_i) disable iff (rst_i)
    cs_valid_i |=> cs_rsp_o.ack) else $error("missing ack");
  a_no_stray_ack: assert property (@(posedge link_clk_i) disable iff (rst_i)
    !cs_valid_i |=> !cs_rsp_o.ack && cs_rsp_o.rdata == 8'h00) else $error("stray answer");
  a_spare_reads_zero: assert property (@(posedge link_clk_i) disable iff (rst_i)
    s_spare_load |=> cs_rsp_o.rdata == 8'h00) else $error("spare slot not zero");
  a_hold_upper_zero: assert property (@(posedge link_clk_i) disable iff (rst_i)
    s_hold_load |=> cs_rsp_o.rdata[7:1] == 7'h00) else $error("reset upper bits set");
  a_key_sets_enable: assert property (@(posedge link_clk_i) disable iff (rst_i)
    key_ok_i |-> ##[1:2] link_nvm_en_o) else $error("key did not enable");
  a_store_clears_en: assert property (@(posedge link_clk_i) disable iff (rst_i)
    s_status_store ##1 !key_ok_i |-> ##[0:1] !link_nvm_en_o) else $error("enable kept");
  a_guard_blocks_tx: assert property (@(posedge link_clk_i) disable iff (rst_i)
    guard_busy_o |-> !tx_grant_o) else $error("grant during guard");
  a_tx_to_rx: assert property (@(posedge link_clk_i) disable iff (rst_i)
    tx_grant_o && !tx_turn_req_i |=> !tx_grant_o && !guard_busy_o) else $error("rx late");
  a_guard_bounded: assert property (@(posedge link_clk_i) disable iff (rst_i)
    guard_busy_o |-> guard_run_r < 8'h80) else $error("guard too long");
  a_core_reset_clear: assert property (@(posedge core_clk_i)
    rst_i |=> !device_reset_o && !nvm_if_en_o) else $error("core outputs kept in reset");

endmodule : dlcsr_top_assertions

`default_nettype wire

// ==== bench/dlcsr_host.sv ====
// Behavioural programmer on the far side of the debug link
`timescale 1ns/1ns
`default_nettype none

module dlcsr_host
  import dlcsr_pkg::*;
  (
    input  wire logic          link_clk_i, // Link clock
    output var  logic          cs_valid_o, // Access strobe
    output var  dlcsr_req_type cs_req_o,   // Access request
    output var  logic          key_ok_o,   // Key accepted
    output var  logic          tx_turn_o   // Transmit wish
  );
  logic [7:0] exp_q[$];  // Expected answer bytes, oldest first

  initial
  begin
    cs_valid_o = 1'b0;
    cs_req_o   = '0;
    key_ok_o   = 1'b0;
    tx_turn_o  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One direct byte access; a store answers zero
  task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d,
                        input logic [7:0] e);
    @(posedge link_clk_i);
    #1;
    cs_valid_o = 1'b1;
    cs_req_o   = '{write: w, addr: a, wdata: d};
    exp_q.push_back(w ? 8'h00 : e);
  endtask : access

  // Release after the taking edge; idle lines keep moving so stale data shows
  task automatic idle();
    @(posedge link_clk_i);
    #1;
    cs_valid_o = 1'b0;
    cs_req_o   = ~cs_req_o;
  endtask : idle

  // Key instruction decoded, one cycle
  task automatic key();
    @(posedge link_clk_i);
    #1;
    key_ok_o = 1'b1;
    @(posedge link_clk_i);
    #1;
    key_ok_o = 1'b0;
  endtask : key

  task automatic turn(input logic v);
    @(posedge link_clk_i);
    #1;
    tx_turn_o = v;
  endtask : turn

endmodule : dlcsr_host

`default_nettype wire

// ==== bench/dlcsr_top_tb_top.sv ====
// Self-checking bench for the debug link control/status block
`timescale 1ns/1ns
`default_nettype none

module dlcsr_top_tb_top;
  import dlcsr_pkg::*;
  logic          core_clk, rst, link_clk, cs_valid, key_ok, tx_turn;
  logic          guard_busy, tx_grant, link_nvm_en, device_reset, nvm_if_en;
  dlcsr_req_type cs_req;
  dlcsr_rsp_type cs_rsp;
  int            failures, checks_done, cycles, k;
  int            seed = 5;
  logic [7:0]    d, n;

  dlcsr_top i_dut (.core_clk_i(core_clk), .rst_i(rst), .link_clk_i(link_clk),
    .cs_valid_i(cs_valid), .cs_req_i(cs_req), .key_ok_i(key_ok), .tx_turn_req_i(tx_turn),
    .cs_rsp_o(cs_rsp), .guard_busy_o(guard_busy), .tx_grant_o(tx_grant),
    .link_nvm_en_o(link_nvm_en), .device_reset_o(device_reset), .nvm_if_en_o(nvm_if_en));
  dlcsr_host i_host (.link_clk_i(link_clk), .cs_valid_o(cs_valid), .cs_req_o(cs_req),
    .key_ok_o(key_ok), .tx_turn_o(tx_turn));

  ////////////////////////////////////////////////////////////////////////////
  // Unrelated clocks: 20 ns core, 6 ns link
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #2;
    forever #3 link_clk = ~link_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic st(input logic [1:0] a, input logic [7:0] v);
    i_host.access(1'b1, a, v, 8'h00);
  endtask : st
  task automatic ld(input logic [1:0] a, input logic [7:0] e);
    i_host.access(1'b0, a, 8'h00, e);
  endtask : ld

  // Wait, bounded, for the device reset level
  task automatic wait_hold(input logic v);
    k = 0;
    while (device_reset !== v && k < 100)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check({7'h00, device_reset}, {7'h00, v}, "device reset");
  endtask : wait_hold

  // One receive-to-transmit turn: grant after bits idle bits, then straight back
  task automatic guard_len(input logic [7:0] bits);
    i_host.turn(1'b1);
    k = 0;
    while (tx_grant !== 1'b1 && k < 200)
    begin
      @(posedge link_clk);
      #1;
      k++;
    end
    check(8'(k), bits + 8'h01, "guard length");
    i_host.turn(1'b0);
    @(posedge link_clk);
    #1;
    check({6'h00, tx_grant, guard_busy}, 8'h00, "rx turn");
  endtask : guard_len

  ////////////////////////////////////////////////////////////////////////////
  // Answer watcher: every ack takes the oldest note
  always @(posedge link_clk)
  begin
    #1;
    if (cs_rsp.ack === 1'b1)
    begin
      if (i_host.exp_q.size() == 0)
        check(8'hxx, 8'h00, "unexpected ack");
      else
        check(cs_rsp.rdata, i_host.exp_q.pop_front(), "read data");
    end
  end

  // Hang guard; the whole run needs well under 2000 core cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge link_clk);
    for (int a = 0; a < 4; a++) ld(2'(a), 8'h00);
    d = 8'($random(seed)) & 8'h07;
    st(OFS_LINK_CONTROL, d);
    ld(OFS_LINK_CONTROL, d);
    i_host.idle();
    $display("test reset values done");
    // Every select code, counting edges up to the grant
    for (int s = 0; s < 8; s++)
    begin
      st(OFS_LINK_CONTROL, 8'(s));
      i_host.idle();
      n = (s >= 6) ? IDLE_BITS_2 : IDLE_BITS_128 >> s;
      guard_len(n);
    end
    // Abort in mid guard on the longest setting, so the drop lands inside it
    st(OFS_LINK_CONTROL, 8'h00);
    i_host.idle();
    i_host.turn(1'b1);
    repeat (3) @(posedge link_clk);
    i_host.turn(1'b0);
    repeat (140) @(posedge link_clk);
    #1;
    check({6'h00, tx_grant, guard_busy}, 8'h00, "aborted guard");
    // A stuck guard would shorten or starve the next turn
    guard_len(IDLE_BITS_128);
    st(OFS_LINK_CONTROL, 8'h07);
    i_host.idle();
    $display("test turnaround done");
    i_host.key();
    repeat (3) @(posedge link_clk);
    ld(OFS_LINK_STATUS, 8'h02);
    i_host.idle();
    check({7'h00, link_nvm_en}, 8'h01, "link enable");
    repeat (6) @(posedge core_clk);
    #1;
    check({7'h00, nvm_if_en}, 8'h01, "core enable");
    st(OFS_LINK_STATUS, 8'h00);
    ld(OFS_LINK_STATUS, 8'h00);
    i_host.idle();
    check({7'h00, link_nvm_en}, 8'h00, "link disable");
    repeat (6) @(posedge core_clk);
    #1;
    check({7'h00, nvm_if_en}, 8'h00, "core disable");
    $display("test enable done");
    st(OFS_REMOTE_RESET_HOLD, RESET_SIGNATURE);
    i_host.idle();
    wait_hold(1'b1);
    repeat (20) @(posedge core_clk);
    ld(OFS_REMOTE_RESET_HOLD, 8'h01);
    i_host.idle();
    check({7'h00, device_reset}, 8'h01, "hold kept");
    d = 8'($random(seed));
    if (d == RESET_SIGNATURE)
      d = 8'h00;
    st(OFS_REMOTE_RESET_HOLD, d);
    i_host.idle();
    wait_hold(1'b0);
    repeat (10) @(posedge core_clk);
    ld(OFS_REMOTE_RESET_HOLD, 8'h00);
    // Low bits kept clear so a store leaking into control would show
    st(OFS_RESERVED_SLOT, 8'($random(seed)) & 8'hf8);
    ld(OFS_RESERVED_SLOT, 8'h00);
    ld(OFS_LINK_CONTROL, 8'h07);
    i_host.idle();
    repeat (4) @(posedge link_clk);
    check(8'(i_host.exp_q.size()), 8'h00, "answers missing");
    $display("test reset hold done");
    print_verdict();
  end

endmodule : dlcsr_top_tb_top

bind dlcsr_top dlcsr_top_assertions i_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .link_clk_i(link_clk_i), .cs_valid_i(cs_valid_i), .cs_req_i(cs_req_i),
  .key_ok_i(key_ok_i), .tx_turn_req_i(tx_turn_req_i), .cs_rsp_o(cs_rsp_o),
  .guard_busy_o(guard_busy_o), .tx_grant_o(tx_grant_o), .link_nvm_en_o(link_nvm_en_o),
  .device_reset_o(device_reset_o), .nvm_if_en_o(nvm_if_en_o));

`default_nettype wire
